// File: bench/fsps_cpu_model.sv
// CPU-side model: register writes, reads and the unlock key sequence
module fsps_cpu_model
	import fsps_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] sfr_rdata,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ========================================================
	// Bus idles low; released data shows the inverse, not the old byte
	initial begin
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
	end

	// One write: drive after a falling edge, hold across one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
	endtask

	// One read: data taken at the rising edge inside the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge core_clk);
		v = sfr_rdata;
		@(negedge core_clk);
		sfr_rd = 1'b0;
	endtask

	// Mode, address and data first; the key pair goes last, uninterrupted
	task automatic op(input logic [7:0] c, input logic [15:0] a,
		input logic [7:0] d);
		wr(FSPS_OFS_CTRL, c);
		wr(FSPS_OFS_ADDR_HI, a[15:8]);
		wr(FSPS_OFS_ADDR_LO, a[7:0]);
		wr(FSPS_OFS_DATA, d);
		wr(FSPS_OFS_KEY, FSPS_KEY_FIRST);
		wr(FSPS_OFS_KEY, FSPS_KEY_SECOND);
	endtask
endmodule

// File: bench/tb_flash_selfprog_sequencer.sv
// Testbench: registers, option decode, boot choice and flash operations
module tb_flash_selfprog_sequencer
	import fsps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short operation counts keep the run small
	localparam int CYC = 4;
	// Rows: in_loader, control, address, data, 0 refused 1 read 2 long
	localparam logic [39:0] ops_tab [21] = '{
		40'h1_83_0205_00_2,
		40'h1_81_0205_FF_1,
		40'h1_82_0205_5A_2,
		40'h1_81_0205_5A_1,
		40'h1_82_0205_0F_2,
		40'h1_81_0205_0A_1,
		40'h1_83_0400_00_2,
		40'h1_82_0400_33_2,
		40'h1_82_03FF_11_2,
		40'h1_83_0200_00_2,
		40'h1_81_03FF_FF_1,
		40'h1_81_0400_33_1,
		40'h1_83_3800_00_0,
		40'h0_83_37FF_00_2,
		40'h0_81_37FF_FF_1,
		40'h0_83_1200_00_2,
		40'h0_83_11FF_00_0,
		40'h0_82_3800_00_0,
		40'h1_80_0205_00_0,
		40'h1_03_0205_00_0,
		40'h0_81_1200_FF_1
	};
	// Rows: address, written, read back
	localparam logic [23:0] reg_tab [7] = '{24'hE5_0B_0B, 24'hE2_77_77,
		24'hE3_A5_A5, 24'hE4_3C_3C, 24'hE7_C3_C3, 24'hE6_46_00,
		24'h80_55_00};
	logic core_clk, reset, power_up, pin_reset, cpu_in_loader;
	logic sfr_wr, sfr_rd, cpu_stall, soft_reset_req, boot_from_loader;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, boot_option;
	logic [7:0] storage_bound_option, v;
	logic loader_present, dump_scramble, code_locked, op_rejected;
	logic [15:0] loader_start, storage_low, storage_high, ls;
	int err_total = 0;
	int compares = 0;
	int n_stall = 0;
	int n_rej = 0;
	int n_sr = 0;
	int s0;

	fsps_sequencer #(.PROG_CYC(CYC), .ERASE_CYC(CYC)) uut (
		.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.boot_option(boot_option),
		.storage_bound_option(storage_bound_option),
		.power_up(power_up), .pin_reset(pin_reset),
		.cpu_in_loader(cpu_in_loader), .osc_freq_code_in(8'h0B),
		.cpu_stall(cpu_stall), .soft_reset_req(soft_reset_req),
		.boot_from_loader(boot_from_loader), .loader_start(loader_start),
		.storage_low(storage_low), .storage_high(storage_high),
		.loader_present(loader_present), .dump_scramble(dump_scramble),
		.code_locked(code_locked), .op_rejected(op_rejected));

	fsps_cpu_model cpu (.core_clk(core_clk), .sfr_rdata(sfr_rdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata));

	// ========================================================
	// Clock and output monitors; counting avoids guessing pulse phase
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		n_stall <= n_stall + int'(cpu_stall === 1'b1);
		n_rej <= n_rej + int'(op_rejected === 1'b1);
		n_sr <= n_sr + int'(soft_reset_req === 1'b1);
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Option change, then a reset-cause pulse, then the boot choice
	task automatic boot_ev(input logic [7:0] o, input logic p,
		input logic e);
		@(negedge core_clk);
		boot_option = o;
		repeat (3) @(negedge core_clk);
		power_up = ~p;
		pin_reset = p;
		@(negedge core_clk);
		power_up = 1'b0;
		pin_reset = 1'b0;
		repeat (2) @(negedge core_clk);
		check(16'(boot_from_loader), 16'(e));
	endtask

	// Read rows preload the inverse so a stale data register shows up
	task automatic step(input logic [39:0] r);
		int j0;
		logic [7:0] d;
		s0 = n_stall;
		j0 = n_rej;
		d = (r[29:28] == 2'h1) ? ~r[11:4] : r[11:4];
		@(negedge core_clk);
		cpu_in_loader = r[36];
		cpu.op(r[35:28], r[27:12], d);
		repeat (15) @(negedge core_clk);
		check(16'(n_stall - s0), (r[3:0] == 4'h1) ? 16'(FSPS_READ_CYC + 1) :
			(r[3:0] == 4'h2) ? 16'(CYC + 1) : 16'h0000);
		check(16'(n_rej - j0), 16'(r[3:0] == 4'h0));
		if (r[3:0] == 4'h1) begin
			cpu.rd(FSPS_OFS_DATA, v);
			check(16'(v), 16'(r[11:4]));
		end
	endtask

	// ========================================================
	// Main sequence
	initial begin
		reset = 1'b1;
		power_up = 1'b0;
		pin_reset = 1'b0;
		cpu_in_loader = 1'b1;
		boot_option = 8'h82;
		storage_bound_option = 8'h12;
		repeat (8) @(negedge core_clk);
		reset = 1'b0;
		foreach (reg_tab[i]) begin
			cpu.wr(reg_tab[i][23:16], reg_tab[i][15:8]);
			cpu.rd(reg_tab[i][23:16], v);
			check(16'(v), 16'(reg_tab[i][7:0]));
		end
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			boot_option = {3'(i), 5'h02};
			repeat (3) @(negedge core_clk);
			ls = (i == 7) ? 16'h4000 : FSPS_LOADER_BASE + 16'(i) * FSPS_LOADER_STEP;
			check(loader_start, ls);
			check(storage_high, ls - 16'h0001);
			check(16'(loader_present), 16'(i != 7));
		end
		check(storage_low, 16'h1200);
		check({14'h0, dump_scramble, code_locked}, 16'h0001);
		boot_ev(8'hE1, 1'b0, 1'b0);
		check({14'h0, dump_scramble, code_locked}, 16'h0002);
		boot_ev(8'h82, 1'b0, 1'b1);
		boot_ev(8'h8E, 1'b1, 1'b0);
		boot_ev(8'h8A, 1'b1, 1'b1);
		boot_ev(8'h8A, 1'b0, 1'b0);
		boot_ev(8'h82, 1'b1, 1'b1);
		boot_ev(8'h82, 1'b0, 1'b1);
		foreach (ops_tab[i])
			step(ops_tab[i]);
		// Key broken by another write, then a wrong second byte
		cpu.wr(FSPS_OFS_CTRL, 8'h81);
		for (int k = 0; k < 2; k++) begin
			s0 = n_stall;
			cpu.wr(FSPS_OFS_KEY, FSPS_KEY_FIRST);
			cpu.wr((k == 0) ? FSPS_OFS_ADDR_LO : FSPS_OFS_KEY, 8'h47);
			cpu.wr(FSPS_OFS_KEY, FSPS_KEY_SECOND);
			repeat (15) @(negedge core_clk);
			check(16'(n_stall - s0), 16'h0000);
		end
		// Soft reset with each boot area choice
		for (int k = 0; k < 2; k++) begin
			cpu.wr(FSPS_OFS_CTRL, (k == 0) ? 8'hE0 : 8'hA0);
			repeat (3) @(negedge core_clk);
			check(16'(boot_from_loader), 16'(k == 0));
		end
		check(16'(n_sr), 16'h0002);
		cpu.rd(FSPS_OFS_CTRL, v);
		check(16'(v), 16'h0080);
		stop_test();
	end

	// Watchdog well beyond the expected run of under a thousand cycles
	initial begin
		#(20 * 8000);
		err_total++;
		stop_test();
	end
endmodule

// File: src/fsps_flash_mem.sv
// Flash array model: byte read through a register, byte AND program, page erase
module fsps_flash_mem
	import fsps_pkg::*;
#(
	parameter int ADDR_W = FSPS_ADDR_W,
	parameter int PAGE_BYTES = FSPS_PAGE_BYTES
) (
	input wire logic core_clk,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic erase,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	localparam int PAGE_W = $clog2(PAGE_BYTES);
	// Page must be a power of two and smaller than the whole array
	if (PAGE_BYTES != (1 << PAGE_W) || PAGE_W >= ADDR_W) begin : g_bad_param
		$error("fsps_flash_mem: unsupported page size");
	end
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	wire [ADDR_W-1:0] page_base = {addr[ADDR_W-1:PAGE_W], PAGE_W'(0)};

	// Erase sets every byte of the page; program only clears bits
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			if (erase) begin
				for (int i = 0; i < PAGE_BYTES; i++) begin
					mem[page_base + ADDR_W'(i)] <= FSPS_ERASED;
				end
			end else if (wr) begin
				mem[addr] <= mem[addr] & wdata;
			end
			if (rd) begin
				rdata <= mem[addr];
			end
		end
	end
endmodule

// File: src/fsps_pkg.sv
// Package: register map, field positions, option codes and timing for the flash sequencer
package fsps_pkg;
	// ========================================================
	// Register offsets on the special function register bus
	localparam logic [7:0] FSPS_OFS_DATA = 8'hE2;
	localparam logic [7:0] FSPS_OFS_ADDR_HI = 8'hE3;
	localparam logic [7:0] FSPS_OFS_ADDR_LO = 8'hE4;
	localparam logic [7:0] FSPS_OFS_TIMING = 8'hE5;
	localparam logic [7:0] FSPS_OFS_KEY = 8'hE6;
	localparam logic [7:0] FSPS_OFS_CTRL = 8'hE7;
	// ========================================================
	// Control register fields
	localparam int FSPS_CTRL_EN_BIT = 7;
	localparam int FSPS_CTRL_SOFT_BOOT_SELECT_BIT = 6;
	localparam int FSPS_CTRL_SOFT_RESET_TRIGGER_BIT = 5;
	localparam logic [7:0] FSPS_CTRL_RESET = 8'h00;
	localparam logic [7:0] FSPS_CTRL_WMASK = 8'hC3;
	// ========================================================
	// Unlock key bytes
	localparam logic [7:0] FSPS_KEY_FIRST = 8'h46;
	localparam logic [7:0] FSPS_KEY_SECOND = 8'hB9;
	// ========================================================
	// Boot option fields
	localparam int FSPS_OPT_SIZE_LSB = 5;
	localparam int FSPS_OPT_POWER_UP_BOOT_SEL_BIT = 3;
	localparam int FSPS_OPT_PIN_RESET_BOOT_SEL_BIT = 2;
	localparam int FSPS_OPT_SCR_BIT = 1;
	localparam int FSPS_OPT_LOCK_BIT = 0;
	localparam logic [2:0] FSPS_SIZE_NONE = 3'h7;
	localparam logic [15:0] FSPS_LOADER_BASE = 16'h3000;
	localparam logic [15:0] FSPS_LOADER_STEP = 16'h0200;
	localparam int FSPS_BOUND_SHIFT = 8;
	// ========================================================
	// Geometry and timing
	localparam int FSPS_PAGE_BYTES = 512;
	localparam int FSPS_ADDR_W = 14;
	localparam int FSPS_CLK_MHZ = 50;
	localparam int FSPS_PROG_US = 20;
	localparam int FSPS_ERASE_US = 40;
	localparam int FSPS_PROG_CYC = FSPS_PROG_US * FSPS_CLK_MHZ;
	localparam int FSPS_ERASE_CYC = FSPS_ERASE_US * FSPS_CLK_MHZ;
	localparam int FSPS_READ_CYC = 2;
	localparam logic [7:0] FSPS_ERASED = 8'hFF;
	// Mode select encodings
	typedef enum logic [1:0] {
		FSPS_MODE_STANDBY = 2'h0,
		FSPS_MODE_READ = 2'h1,
		FSPS_MODE_PROG = 2'h2,
		FSPS_MODE_ERASE = 2'h3
	} fsps_mode_t;
endpackage

// File: src/fsps_sequencer.sv
// Top: flash self-programming sequencer with registers, key unlock and options
// Notes on behaviour
// - Mode 0,1 reads the flash byte at the loaded address.
// - An operation starts only after key 0x46 then 0xB9.
// - A finished read puts the byte into the data register.
// - The CPU is stalled while an operation runs.
// - Mode 1,1 erases the page holding the loaded address.
// - Mode 1,0 programs the data byte at the loaded address.
// - Loader runs target the application area; others the storage area.
// - Storage area spans bound times 256 up to loader start minus one.
// - Erase is per 512 byte page only.
// - Storage contents are readable by code fetch and by read mode.
// - Size codes 0 to 6 give loader start 0x3000 plus 0x200 steps.
// - Power-up boot option 0 boots from a configured loader.
// - Pin-reset boot option 0 makes pin reset boot loader too.
// - Scramble option 0 scrambles externally dumped code.
// - Lock option 0 protects code against readout.
// - Option bytes are inputs; firmware cannot write them.
// - Control bit 7 enables; operations accepted only while set.
// - Control bit 5 triggers soft reset; bit 6 picks its boot area.
module fsps_sequencer
	import fsps_pkg::*;
#(
	parameter int ADDR_W = FSPS_ADDR_W,
	parameter int PROG_CYC = FSPS_PROG_CYC,
	parameter int ERASE_CYC = FSPS_ERASE_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [7:0] boot_option,
	input wire logic [7:0] storage_bound_option,
	input wire logic power_up,
	input wire logic pin_reset,
	input wire logic cpu_in_loader,
	input wire logic [7:0] osc_freq_code_in,
	output logic cpu_stall,
	output logic soft_reset_req,
	output logic boot_from_loader,
	output logic [15:0] loader_start,
	output logic [15:0] storage_low,
	output logic [15:0] storage_high,
	output logic loader_present,
	output logic dump_scramble,
	output logic code_locked,
	output logic op_rejected
);
	// Refuse sizes the 16-bit counter and address window cannot serve;
	// a full 16-bit array would leave no code for the no-loader limit
	if (ADDR_W < 14 || ADDR_W > 15 || PROG_CYC < 1 || ERASE_CYC < 1 ||
		PROG_CYC > 65536 || ERASE_CYC > 65536) begin : g_bad_param
		$error("fsps_sequencer: unsupported parameters");
	end

	typedef enum logic [1:0] {FSPS_IDLE, FSPS_RUN, FSPS_DONE} fsps_state_t;

	// ========================================================
	// Registers
	logic [7:0] data_q, addr_hi_q, addr_lo_q, timing_q, ctrl_q;
	logic key_armed_q;
	fsps_state_t state_q, state_d;
	logic [15:0] cnt_q;
	logic [1:0] op_q;
	logic [7:0] opt_boot_q, opt_bound_q;
	logic boot_sel_q, soft_rst_q, rej_q;
	logic [7:0] mem_rdata;

	// Option bytes come from the fuse pins: sampled twice
	logic [7:0] boot_s1_q, bound_s1_q;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			boot_s1_q <= 8'hFF;
			bound_s1_q <= 8'h00;
			opt_boot_q <= 8'hFF;
			opt_bound_q <= 8'h00;
		end else if (clk_en) begin
			boot_s1_q <= boot_option;
			bound_s1_q <= storage_bound_option;
			opt_boot_q <= boot_s1_q;
			opt_bound_q <= bound_s1_q;
		end
	end

	// ========================================================
	// Option decode: loader start, storage window, security
	wire [2:0] size_sel = opt_boot_q[FSPS_OPT_SIZE_LSB +: 3];
	assign loader_present = size_sel != FSPS_SIZE_NONE;
	assign loader_start = loader_present ?
		16'(FSPS_LOADER_BASE + FSPS_LOADER_STEP * 16'(size_sel)) :
		16'((1 << ADDR_W));
	assign storage_low = {opt_bound_q, 8'h00};
	assign storage_high = 16'(loader_start - 16'h0001);
	assign dump_scramble = ~opt_boot_q[FSPS_OPT_SCR_BIT];
	assign code_locked = ~opt_boot_q[FSPS_OPT_LOCK_BIT];

	// Reset causes come from the reset pins: sampled twice as well
	logic pu_s1_q, pu_s2_q, pin_s1_q, pin_s2_q;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			{pu_s1_q, pu_s2_q, pin_s1_q, pin_s2_q} <= 4'h0;
		end else if (clk_en) begin
			pu_s1_q <= power_up;
			pu_s2_q <= pu_s1_q;
			pin_s1_q <= pin_reset;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Boot source: soft reset choice, then power-up, then pin reset
	wire hw_pu = ~opt_boot_q[FSPS_OPT_POWER_UP_BOOT_SEL_BIT] & loader_present;
	wire hw_pin = ~opt_boot_q[FSPS_OPT_PIN_RESET_BOOT_SEL_BIT] & loader_present;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			boot_sel_q <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst_q)
				boot_sel_q <= ctrl_q[FSPS_CTRL_SOFT_BOOT_SELECT_BIT];
			else if (pu_s2_q)
				boot_sel_q <= hw_pu;
			else if (pin_s2_q)
				boot_sel_q <= hw_pin | hw_pu;
		end
	end
	assign boot_from_loader = boot_sel_q;

	// ========================================================
	// Address window check
	wire [15:0] full_addr = {addr_hi_q, addr_lo_q};
	wire in_storage = full_addr >= storage_low && full_addr <= storage_high;
	wire in_app = full_addr < loader_start;
	// Loader firmware may touch the whole application area; others only storage
	wire addr_ok = cpu_in_loader ? in_app : in_storage;
	wire [1:0] mode = ctrl_q[1:0];

	// ========================================================
	// Bus decode
	wire wr_data = sfr_wr && sfr_addr == FSPS_OFS_DATA;
	wire wr_hi = sfr_wr && sfr_addr == FSPS_OFS_ADDR_HI;
	wire wr_lo = sfr_wr && sfr_addr == FSPS_OFS_ADDR_LO;
	wire wr_tim = sfr_wr && sfr_addr == FSPS_OFS_TIMING;
	wire wr_key = sfr_wr && sfr_addr == FSPS_OFS_KEY;
	wire wr_ctrl = sfr_wr && sfr_addr == FSPS_OFS_CTRL;
	wire key1 = wr_key && sfr_wdata == FSPS_KEY_FIRST;
	// Any bus write in between the two keys breaks the sequence
	wire key2 = wr_key && key_armed_q && sfr_wdata == FSPS_KEY_SECOND;
	wire enabled = ctrl_q[FSPS_CTRL_EN_BIT];
	wire go = key2 && enabled && mode != FSPS_MODE_STANDBY && addr_ok
		&& state_q == FSPS_IDLE;
	wire reject = key2 && !go;

	// Key tracker: one write of anything else discards the armed key
	always_ff @(posedge core_clk) begin
		if (reset)
			key_armed_q <= 1'b0;
		else if (clk_en && sfr_wr)
			key_armed_q <= key1 && !cpu_stall;
	end

	// Software registers; the data register is reloaded by a read
	always_ff @(posedge core_clk) begin
		if (reset) begin
			data_q <= 8'h00;
			addr_hi_q <= 8'h00;
			addr_lo_q <= 8'h00;
			timing_q <= 8'h00;
			ctrl_q <= FSPS_CTRL_RESET;
		end else if (clk_en) begin
			if (state_q == FSPS_DONE && op_q == FSPS_MODE_READ)
				data_q <= mem_rdata;
			else if (wr_data)
				data_q <= sfr_wdata;
			if (wr_hi)
				addr_hi_q <= sfr_wdata;
			if (wr_lo)
				addr_lo_q <= sfr_wdata;
			if (wr_tim)
				timing_q <= sfr_wdata;
			if (wr_ctrl)
				ctrl_q <= sfr_wdata & FSPS_CTRL_WMASK;
		end
	end

	// Soft reset request is a single pulse per write of bit 5
	always_ff @(posedge core_clk) begin
		if (reset) begin
			soft_rst_q <= 1'b0;
			rej_q <= 1'b0;
		end else if (clk_en) begin
			soft_rst_q <= wr_ctrl && sfr_wdata[FSPS_CTRL_SOFT_RESET_TRIGGER_BIT];
			rej_q <= reject;
		end
	end
	assign soft_reset_req = soft_rst_q;
	assign op_rejected = rej_q;

	// Read mux; key register is write-only and reads zero
	always_comb begin
		unique case (sfr_addr)
			FSPS_OFS_DATA: sfr_rdata = data_q;
			FSPS_OFS_ADDR_HI: sfr_rdata = addr_hi_q;
			FSPS_OFS_ADDR_LO: sfr_rdata = addr_lo_q;
			FSPS_OFS_TIMING: sfr_rdata = timing_q;
			FSPS_OFS_CTRL: sfr_rdata = ctrl_q;
			default: sfr_rdata = 8'h00;
		endcase
	end

	// ========================================================
	// Operation sequencer
	wire cnt_done = cnt_q == 16'h0000;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			FSPS_IDLE: if (go) state_d = FSPS_RUN;
			FSPS_RUN: if (cnt_done) state_d = FSPS_DONE;
			FSPS_DONE: state_d = FSPS_IDLE;
		endcase
	end

	// Busy time is a fixed count; osc_freq_code_in is unused and the timing register holds only software writes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= FSPS_IDLE;
			cnt_q <= 16'h0000;
			op_q <= FSPS_MODE_STANDBY;
		end else if (clk_en) begin
			state_q <= state_d;
			if (go) begin
				op_q <= mode;
				unique case (mode)
					FSPS_MODE_ERASE: cnt_q <= 16'(ERASE_CYC - 1);
					FSPS_MODE_PROG: cnt_q <= 16'(PROG_CYC - 1);
					default: cnt_q <= 16'(FSPS_READ_CYC - 1);
				endcase
			end else if (!cnt_done) begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end

	// CPU waits from the trigger until the data register holds the result
	assign cpu_stall = state_q != FSPS_IDLE;

	wire last = state_q == FSPS_RUN && cnt_done;
	fsps_flash_mem #(.ADDR_W(ADDR_W), .PAGE_BYTES(FSPS_PAGE_BYTES)) u_mem (
		.core_clk(core_clk),
		.clk_en(clk_en),
		.addr(full_addr[ADDR_W-1:0]),
		.rd(last && op_q == FSPS_MODE_READ),
		.wr(last && op_q == FSPS_MODE_PROG),
		.erase(last && op_q == FSPS_MODE_ERASE),
		.wdata(data_q),
		.rdata(mem_rdata)
	);

	// ========================================================
	// Checks
	key_needed_a: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en && $rose(cpu_stall) |-> $past(key_armed_q))
		else $error("Start without first key");
	stall_hold_a: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en && go |=> cpu_stall)
		else $error("No stall after start");
	standby_idle_a: assert property (
		@(posedge core_clk) disable iff (reset)
		key2 && mode == FSPS_MODE_STANDBY |=> !cpu_stall)
		else $error("Standby started an operation");
	disabled_idle_a: assert property (
		@(posedge core_clk) disable iff (reset)
		key2 && !enabled |=> !cpu_stall)
		else $error("Disabled sequencer ran");
	read_len_a: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en && go && mode == FSPS_MODE_READ |=> cpu_stall [*3] ##1
		(clk_en -> !cpu_stall))
		else $error("Read stall length wrong");
	low_bound_a: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en && go && !cpu_in_loader |->
		full_addr[15:8] >= opt_bound_q && full_addr < loader_start)
		else $error("Start outside storage area");
	app_area_a: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en && go && cpu_in_loader |-> full_addr < loader_start)
		else $error("Loader start beyond application area");
	reject_pulse_a: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en && key2 && !go |=> op_rejected && !cpu_stall)
		else $error("Refused key pair not flagged");
	loader_map_a: assert property (
		@(posedge core_clk) disable iff (reset)
		loader_present |-> loader_start[8:0] == 9'h000 &&
		loader_start >= 16'h3000 && loader_start <= 16'h3C00)
		else $error("Loader start out of range");
	lock_map_a: assert property (
		@(posedge core_clk) disable iff (reset)
		code_locked != opt_boot_q[FSPS_OPT_LOCK_BIT] &&
		dump_scramble != opt_boot_q[FSPS_OPT_SCR_BIT])
		else $error("Security decode wrong");
	soft_rst_a: assert property (
		@(posedge core_clk) disable iff (reset)
		clk_en && wr_ctrl && sfr_wdata[FSPS_CTRL_SOFT_RESET_TRIGGER_BIT] |=>
		soft_reset_req)
		else $error("Soft reset missed");
	read_c: cover property (@(posedge core_clk) disable iff (reset)
		go && mode == FSPS_MODE_READ);
	prog_c: cover property (@(posedge core_clk) disable iff (reset)
		go && mode == FSPS_MODE_PROG);
	erase_c: cover property (@(posedge core_clk) disable iff (reset)
		go && mode == FSPS_MODE_ERASE);
	reject_c: cover property (@(posedge core_clk) disable iff (reset)
		op_rejected);
endmodule
